// ===== verilog/fsd_pkg.sv
/*
 * Package for the boot-sector flash host controller: pin bundles, command
 * and autoselect codes, timing constants and sector decode helpers.
 * Assumes a byte-wide asynchronous flash with a 17-bit address bus.
 */
package fsd_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int CLK_MHZ = 40;
   // Nominal times in ns; a real part's figures replace these defaults.
   localparam int ACCESS_TIME_NS = 90;
   localparam int MIN_CLEAR_PULSE_NS = 500;
   localparam int CLEAR_RECOVER_NS = 50;
   localparam int SLEEP_EXTRA_NS = 30;
   localparam int WRITE_PULSE_NS = 35;
   // Least times round up to whole cycles.
   localparam int ACCESS_CYC = (ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CLEAR_CYC = (MIN_CLEAR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_CYC = (CLEAR_RECOVER_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SLEEP_CYC =
      ((ACCESS_TIME_NS + SLEEP_EXTRA_NS) * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;

   localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 17'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 17'h002aa;
   localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'haa;
   localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [DATA_W-1:0] AUTOSEL_CMD = 8'h90;
   localparam logic [DATA_W-1:0] RESET_CMD = 8'hf0;
   localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 17'h00000;
   localparam logic [ADDR_W-1:0] ID_DEVICE_ADDR = 17'h00001;
   localparam logic [ADDR_W-1:0] ID_PROT_ADDR = 17'h00002;
   localparam logic [DATA_W-1:0] PROT_NO = 8'h00;
   localparam logic [DATA_W-1:0] PROT_YES = 8'h01;
   localparam int SEC_LSB = 12;
   localparam int SEC_W = 5;

   typedef enum logic [2:0] {
      OP_READ = 3'b000,
      OP_WRITE = 3'b001,
      OP_ID_CMD = 3'b010,
      OP_ID_HV = 3'b011,
      OP_EXIT_ID = 3'b100,
      OP_CLEAR = 3'b101,
      OP_STANDBY = 3'b110
   } fsd_op_e;

   typedef enum logic [1:0] {
      ID_MAKER = 2'b00,
      ID_DEVICE = 2'b01,
      ID_PROT = 2'b10
   } fsd_id_e;

   typedef struct packed {
      fsd_op_e op;
      fsd_id_e id;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fsd_req_s;

   typedef struct packed {
      logic sel_n;
      logic gate_n;
      logic wstb_n;
      logic clear_n;
      logic hv_id;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic doe;
   } fsd_pins_s;

   // Index of the sector that holds an address, for either boot variant.
   function automatic logic [3:0] sector_of(input logic top_boot,
                                            input logic [ADDR_W-1:0] a);
      logic [2:0] hi;
      hi = a[16:14];
      if (top_boot) begin
         if (hi != 3'h7) sector_of = {1'b0, hi};
         else if (a[13]) sector_of = 4'h9;
         else sector_of = a[12] ? 4'h8 : 4'h7;
      end else begin
         if (hi != 3'h0) sector_of = {1'b0, hi} + 4'h2;
         else if (!a[13]) sector_of = 4'h0;
         else sector_of = a[12] ? 4'h2 : 4'h1;
      end
   endfunction : sector_of
endpackage : fsd_pkg

// ===== verilog/fsd_host.sv
/*
 * Host controller for a byte-wide boot-sector flash: array reads and
 * writes, command and high-voltage autoselect, hardware clear and standby.
 * Assumes the flash data pins are resolved by the bench from DATA_OE_O.
 */
`timescale 1ns/1ps
`default_nettype none
module fsd_host #(
   parameter bit TOP_BOOT = 1'b1
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic REQ_VALID_I,
   input wire fsd_pkg::fsd_req_s REQ_I,
   output logic REQ_READY_O,
   output logic DONE_O,
   output logic [fsd_pkg::DATA_W-1:0] RDATA_O,
   output logic [3:0] SECTOR_O,
   output logic PROT_O,
   output logic SEL_N_O,
   output logic GATE_N_O,
   output logic WSTB_N_O,
   output logic CLEAR_N_O,
   output logic HV_ID_O,
   output logic [fsd_pkg::ADDR_W-1:0] ADDR_O,
   output logic [fsd_pkg::DATA_W-1:0] DATA_O,
   output logic DATA_OE_O,
   input wire logic [fsd_pkg::DATA_W-1:0] DATA_I
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_WRITE = 3'b010,
      ST_GAP = 3'b011,
      ST_CLEAR = 3'b100,
      ST_RECOVER = 3'b101,
      ST_STANDBY = 3'b110
   } fsd_st_e;

   typedef struct packed {
      fsd_st_e st;
      fsd_pkg::fsd_op_e op;
      logic [1:0] step;
      logic [fsd_pkg::CNT_W-1:0] cnt;
      fsd_pkg::fsd_pins_s pins;
      logic [fsd_pkg::DATA_W-1:0] d1_r;
      logic [fsd_pkg::DATA_W-1:0] d2_r;
      logic [fsd_pkg::DATA_W-1:0] rdata;
      logic [3:0] sector;
      logic prot;
      logic done;
      fsd_pkg::fsd_req_s req;
   } fsd_state_s;

   localparam fsd_pkg::fsd_pins_s PINS_IDLE = '{sel_n: 1'b1, gate_n: 1'b1,
      wstb_n: 1'b1, clear_n: 1'b1, hv_id: 1'b0, addr: '0, dout: '0,
      doe: 1'b0};
   // The read count also covers the two-stage data synchroniser, so the
   // byte that reaches the second stage was taken after the access time.
   localparam int SYNC_CYC = 2;
   localparam logic [fsd_pkg::CNT_W-1:0] ACC_C =
      fsd_pkg::CNT_W'(fsd_pkg::ACCESS_CYC + SYNC_CYC);
   localparam logic [fsd_pkg::CNT_W-1:0] CLR_C =
      fsd_pkg::CNT_W'(fsd_pkg::CLEAR_CYC);
   localparam logic [fsd_pkg::CNT_W-1:0] REC_C =
      fsd_pkg::CNT_W'(fsd_pkg::RECOVER_CYC);
   localparam logic [fsd_pkg::CNT_W-1:0] WR_C =
      fsd_pkg::CNT_W'(fsd_pkg::WRITE_CYC);

   fsd_state_s s_r;
   fsd_state_s s_nxt;

   // Identity address with every don't-care bit held low.
   function automatic logic [fsd_pkg::ADDR_W-1:0] id_addr(
         input fsd_pkg::fsd_req_s rq);
      logic [fsd_pkg::ADDR_W-1:0] a;
      a = '0;
      unique case (rq.id)
         fsd_pkg::ID_MAKER: a = fsd_pkg::ID_MAKER_ADDR;
         fsd_pkg::ID_DEVICE: a = fsd_pkg::ID_DEVICE_ADDR;
         default: begin
            a = fsd_pkg::ID_PROT_ADDR;
            a[fsd_pkg::ADDR_W-1:fsd_pkg::SEC_LSB] =
               rq.addr[fsd_pkg::ADDR_W-1:fsd_pkg::SEC_LSB];
         end
      endcase
      id_addr = a;
   endfunction : id_addr

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      // The data pins are asynchronous; only the second stage is read.
      s_nxt.d1_r = DATA_I;
      s_nxt.d2_r = s_r.d1_r;
      unique case (s_r.st)
         ST_IDLE: begin
            s_nxt.pins = PINS_IDLE;
            if (REQ_VALID_I) begin
               s_nxt.req = REQ_I;
               s_nxt.op = REQ_I.op;
               s_nxt.step = 2'd0;
               unique case (REQ_I.op)
                  fsd_pkg::OP_READ: begin
                     s_nxt.st = ST_READ;
                     s_nxt.cnt = ACC_C;
                     s_nxt.pins.addr = REQ_I.addr;
                     s_nxt.pins.sel_n = 1'b0;
                     s_nxt.pins.gate_n = 1'b0;
                  end
                  fsd_pkg::OP_ID_HV: begin
                     s_nxt.st = ST_READ;
                     s_nxt.cnt = ACC_C;
                     s_nxt.pins.hv_id = 1'b1;
                     s_nxt.pins.addr = id_addr(REQ_I);
                     s_nxt.pins.sel_n = 1'b0;
                     s_nxt.pins.gate_n = 1'b0;
                  end
                  fsd_pkg::OP_CLEAR, fsd_pkg::OP_STANDBY: begin
                     // Aborted program or erase is for the requester to redo.
                     s_nxt.st = ST_CLEAR;
                     s_nxt.cnt = CLR_C;
                     s_nxt.pins.clear_n = 1'b0;
                  end
                  default: begin
                     s_nxt.st = ST_WRITE;
                     s_nxt.cnt = WR_C;
                  end
               endcase
            end
         end
         ST_WRITE: begin
            // Gate stays high so the flash floats its pins while we drive.
            s_nxt.pins.sel_n = 1'b0;
            s_nxt.pins.gate_n = 1'b1;
            s_nxt.pins.wstb_n = 1'b0;
            s_nxt.pins.doe = 1'b1;
            if (s_r.op == fsd_pkg::OP_WRITE) begin
               s_nxt.pins.addr = s_r.req.addr;
               s_nxt.pins.dout = s_r.req.data;
            end else if (s_r.op == fsd_pkg::OP_EXIT_ID) begin
               s_nxt.pins.addr = '0;
               s_nxt.pins.dout = fsd_pkg::RESET_CMD;
            end else begin
               unique case (s_r.step)
                  2'd0: begin
                     s_nxt.pins.addr = fsd_pkg::UNLOCK_ADDR1;
                     s_nxt.pins.dout = fsd_pkg::UNLOCK_DATA1;
                  end
                  2'd1: begin
                     s_nxt.pins.addr = fsd_pkg::UNLOCK_ADDR2;
                     s_nxt.pins.dout = fsd_pkg::UNLOCK_DATA2;
                  end
                  default: begin
                     s_nxt.pins.addr = fsd_pkg::UNLOCK_ADDR1;
                     s_nxt.pins.dout = fsd_pkg::AUTOSEL_CMD;
                  end
               endcase
            end
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - 1'b1;
            end else begin
               s_nxt.pins.wstb_n = 1'b1;
               s_nxt.st = ST_GAP;
            end
         end
         ST_GAP: begin
            // Strobe rises first; data releases one cycle later, and select too unless the command autoselect read follows.
            s_nxt.pins = PINS_IDLE;
            s_nxt.cnt = WR_C;
            if (s_r.op == fsd_pkg::OP_ID_CMD && s_r.step != 2'd2) begin
               s_nxt.step = s_r.step + 2'd1;
               s_nxt.st = ST_WRITE;
            end else if (s_r.op == fsd_pkg::OP_ID_CMD) begin
               s_nxt.st = ST_READ;
               s_nxt.cnt = ACC_C;
               s_nxt.pins.addr = id_addr(s_r.req);
               s_nxt.pins.sel_n = 1'b0;
               s_nxt.pins.gate_n = 1'b0;
            end else begin
               s_nxt.st = ST_IDLE;
               s_nxt.done = 1'b1;
            end
         end
         ST_READ: begin
            // Data is sampled only after a full access time from the address.
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - 1'b1;
            end else begin
               s_nxt.rdata = s_r.d2_r;
               s_nxt.sector = fsd_pkg::sector_of(TOP_BOOT,
                  s_r.req.addr);
               s_nxt.prot = (s_r.req.id == fsd_pkg::ID_PROT) &&
                  (s_r.d2_r == fsd_pkg::PROT_YES);
               s_nxt.pins = PINS_IDLE;
               s_nxt.st = ST_IDLE;
               s_nxt.done = 1'b1;
            end
         end
         ST_CLEAR: begin
            s_nxt.pins.clear_n = 1'b0;
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - 1'b1;
            end else if (s_r.op == fsd_pkg::OP_STANDBY) begin
               s_nxt.st = ST_STANDBY;
            end else begin
               s_nxt.pins.clear_n = 1'b1;
               s_nxt.cnt = REC_C;
               s_nxt.st = ST_RECOVER;
            end
         end
         ST_STANDBY: begin
            s_nxt.pins.clear_n = 1'b0;
            if (REQ_VALID_I) begin
               s_nxt.pins.clear_n = 1'b1;
               s_nxt.cnt = REC_C;
               s_nxt.st = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            // The flash is back in array read once this wait ends.
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - 1'b1;
            end else begin
               s_nxt.st = ST_IDLE;
               s_nxt.done = 1'b1;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
            s_nxt.pins = PINS_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.pins <= PINS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // A standby wake request is consumed only as the trigger to leave.
   assign REQ_READY_O = (s_r.st == ST_IDLE) || (s_r.st == ST_STANDBY);
   assign DONE_O = s_r.done;
   assign RDATA_O = s_r.rdata;
   assign SECTOR_O = s_r.sector;
   assign PROT_O = s_r.prot;
   assign SEL_N_O = s_r.pins.sel_n;
   assign GATE_N_O = s_r.pins.gate_n;
   assign WSTB_N_O = s_r.pins.wstb_n;
   assign CLEAR_N_O = s_r.pins.clear_n;
   assign HV_ID_O = s_r.pins.hv_id;
   assign ADDR_O = s_r.pins.addr;
   assign DATA_O = s_r.pins.dout;
   assign DATA_OE_O = s_r.pins.doe;
endmodule : fsd_host
`default_nettype wire

// ===== bench/fsd_host_asserts.sv
/* Pin-level checker for fsd_host.
   Bound into every fsd_host instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module fsd_host_chk (
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic REQ_VALID_I,
   input wire fsd_pkg::fsd_req_s REQ_I,
   input wire logic REQ_READY_O,
   input wire logic SEL_N_O,
   input wire logic GATE_N_O,
   input wire logic WSTB_N_O,
   input wire logic CLEAR_N_O,
   input wire logic HV_ID_O,
   input wire logic [fsd_pkg::ADDR_W-1:0] ADDR_O,
   input wire logic [fsd_pkg::DATA_W-1:0] DATA_O,
   input wire logic DATA_OE_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic tk;
   logic [7:0] low_r;
   assign tk = REQ_VALID_I && REQ_READY_O && CLEAR_N_O;
   // Saturates so a long standby cannot wrap into a short pulse.
   always_ff @(posedge SYS_CLK_I)
      low_r <= (!RST_N_I || CLEAR_N_O) ? 8'h00 : low_r + {7'h0, ~&low_r};
   property p_rd; !SEL_N_O && !GATE_N_O |-> WSTB_N_O && !DATA_OE_O;
   endproperty
   a_rd: assert property (p_rd) else $error("read with strobe");
   property p_oe; DATA_OE_O |-> GATE_N_O && !SEL_N_O; endproperty
   a_oe: assert property (p_oe) else $error("drive with gate");
   property p_cq; !CLEAR_N_O |-> SEL_N_O && WSTB_N_O && !HV_ID_O;
   endproperty
   a_cq: assert property (p_cq) else $error("access in clear");
   property p_cl; $rose(CLEAR_N_O) |-> low_r >= fsd_pkg::CLEAR_CYC;
   endproperty
   a_cl: assert property (p_cl) else $error("clear too short");
   property p_sb; tk && REQ_I.op == fsd_pkg::OP_STANDBY
      |-> ##[1:3] !CLEAR_N_O [*8]; endproperty
   a_sb: assert property (p_sb) else $error("no standby");
   property p_hv; HV_ID_O |-> WSTB_N_O && !ADDR_O[6] && !(&ADDR_O[1:0]);
   endproperty
   a_hv: assert property (p_hv) else $error("bad id address");
   property p_ht; tk && REQ_I.op == fsd_pkg::OP_ID_HV |-> ##[1:2] HV_ID_O;
   endproperty
   a_ht: assert property (p_ht) else $error("no id voltage");
   property p_pa; tk && REQ_I.op == fsd_pkg::OP_ID_HV
      && REQ_I.id == fsd_pkg::ID_PROT |-> ##1 ADDR_O[1:0] == 2'b10
      && ADDR_O[16:12] == $past(REQ_I.addr[16:12]); endproperty
   a_pa: assert property (p_pa) else $error("bad prot address");
   // Write pins show one cycle after the write state has been loaded.
   property p_ul; tk && REQ_I.op == fsd_pkg::OP_ID_CMD |-> ##2 !WSTB_N_O
      && ADDR_O == fsd_pkg::UNLOCK_ADDR1 && DATA_O == fsd_pkg::UNLOCK_DATA1;
   endproperty
   a_ul: assert property (p_ul) else $error("bad unlock");
   property p_ex; tk && REQ_I.op == fsd_pkg::OP_EXIT_ID
      |-> ##2 !WSTB_N_O && DATA_O == fsd_pkg::RESET_CMD; endproperty
   a_ex: assert property (p_ex) else $error("bad exit");
   property p_wr; tk && REQ_I.op == fsd_pkg::OP_WRITE |-> ##2 !WSTB_N_O
      && GATE_N_O && ADDR_O == $past(REQ_I.addr, 2)
      && DATA_O == $past(REQ_I.data, 2); endproperty
   a_wr: assert property (p_wr) else $error("bad write");
endmodule : fsd_host_chk
bind fsd_host fsd_host_chk i_chk (.SYS_CLK_I, .RST_N_I, .REQ_VALID_I,
   .REQ_I, .REQ_READY_O, .SEL_N_O, .GATE_N_O, .WSTB_N_O, .CLEAR_N_O,
   .HV_ID_O, .ADDR_O, .DATA_O, .DATA_OE_O);
`default_nettype wire

// ===== bench/fsd_flash_mdl.sv
/* Behavioural byte-wide boot-sector flash facing the host pins.
   Assumes the bench resolves the shared data pins from both enables. */
`timescale 1ns/1ps
`default_nettype none
module fsd_flash_mdl #(
   parameter int ACC_NS = 90,
   parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value.
   parameter logic [7:0] DEVICE = 8'ha5, // Arbitrary value.
   parameter logic [7:0] PROT_HI = 8'h04
) (
   input wire logic sel_n_i,
   input wire logic gate_n_i,
   input wire logic wstb_n_i,
   input wire logic clear_n_i,
   input wire logic hv_i,
   input wire logic [16:0] addr_i,
   input wire logic [7:0] din_i,
   output logic [7:0] dq_o,
   output logic dq_oe_o
);
   // Power-up leaves the command logic in array read.
   logic [1:0] seq_r = 2'h0;
   logic auto_r = 1'b0;
   logic [7:0] val;
   always @(posedge wstb_n_i or negedge clear_n_i) begin
      if (!clear_n_i) begin
         seq_r <= 2'h0;
         auto_r <= 1'b0;
      end else if (!sel_n_i && gate_n_i) begin
         seq_r <= 2'h0;
         if (din_i == 8'hf0)
            auto_r <= 1'b0;
         else if (seq_r == 2'h0 && addr_i == 17'h00555 && din_i == 8'haa)
            seq_r <= 2'h1;
         else if (seq_r == 2'h1 && addr_i == 17'h002aa && din_i == 8'h55)
            seq_r <= 2'h2;
         else if (seq_r == 2'h2 && addr_i == 17'h00555 && din_i == 8'h90)
            auto_r <= 1'b1;
      end
   end
   always_comb begin
      if (hv_i || auto_r) begin
         case (addr_i[1:0])
            2'b00: val = MAKER;
            2'b01: val = DEVICE;
            default: val = {7'h00, PROT_HI[addr_i[16:14]]};
         endcase
      end else
         val = addr_i[7:0] ^ addr_i[15:8] ^ {7'h00, addr_i[16]};
   end
   // Inertial delay: new data after an access time, last data held.
   assign #(ACC_NS) dq_o = val;
   assign dq_oe_o = !sel_n_i && !gate_n_i && clear_n_i;
endmodule : fsd_flash_mdl
`default_nettype wire

// ===== bench/tb.sv
/* Self-checking bench: fsd_host driving the behavioural flash.
   Assumes the package timing defaults and the top-boot decode. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] MAKER_ID = 8'h3c; // Arbitrary value.
   localparam logic [7:0] DEV_ID = 8'ha5; // Arbitrary value.
   logic clk, rst_n, valid, ready, done, prot, sel_n, gate_n, wstb_n;
   logic clear_n, hv, doe, moe;
   fsd_pkg::fsd_req_s req;
   logic [7:0] rdata, dout, din, mdq, flt;
   logic [3:0] sector, sector_b;
   logic [16:0] addr, a;
   logic [31:0] lfsr;
   int error_cnt, cmp_count;
   logic [16:0] corner [8] = '{17'h1bfff, 17'h1c000, 17'h1d000, 17'h1e000,
      17'h01fff, 17'h02000, 17'h03000, 17'h04000};
   // No pull on the data pins, so a floating bus shows a moving pattern.
   assign din = doe ? dout : (moe ? mdq : flt);
   always @(posedge clk) flt <= ~flt + 8'h01;
   fsd_host #(.TOP_BOOT(1'b1)) i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .REQ_VALID_I(valid), .REQ_I(req), .REQ_READY_O(ready), .DONE_O(done),
      .RDATA_O(rdata), .SECTOR_O(sector), .PROT_O(prot), .SEL_N_O(sel_n),
      .GATE_N_O(gate_n), .WSTB_N_O(wstb_n), .CLEAR_N_O(clear_n),
      .HV_ID_O(hv), .ADDR_O(addr), .DATA_O(dout), .DATA_OE_O(doe),
      .DATA_I(din));
   fsd_flash_mdl #(.MAKER(MAKER_ID), .DEVICE(DEV_ID)) i_mem (
      .sel_n_i(sel_n), .gate_n_i(gate_n), .wstb_n_i(wstb_n),
      .clear_n_i(clear_n), .hv_i(hv), .addr_i(addr), .din_i(din),
      .dq_o(mdq), .dq_oe_o(moe));
   // Bottom-boot twin shares the stimulus; only its decode is compared.
   fsd_host #(.TOP_BOOT(1'b0)) i_dut_b (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .REQ_VALID_I(valid), .REQ_I(req), .REQ_READY_O(), .DONE_O(),
      .RDATA_O(), .SECTOR_O(sector_b), .PROT_O(), .SEL_N_O(),
      .GATE_N_O(), .WSTB_N_O(), .CLEAR_N_O(), .HV_ID_O(), .ADDR_O(),
      .DATA_O(), .DATA_OE_O(), .DATA_I(din));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   function automatic logic [7:0] mem_exp(input logic [16:0] x);
      return x[7:0] ^ x[15:8] ^ {7'h00, x[16]};
   endfunction : mem_exp
   function automatic logic [3:0] sec_exp(input logic [16:0] x);
      if (x[16:14] != 3'h7)
         return {1'b0, x[16:14]};
      return x[13] ? 4'h9 : 4'h7 + {3'h0, x[12]};
   endfunction : sec_exp
   function automatic logic [3:0] sec_bot_exp(input logic [16:0] x);
      if (x[16:14] != 3'h0)
         return {1'b0, x[16:14]} + 4'h2;
      return x[13] ? 4'h1 + {3'h0, x[12]} : 4'h0;
   endfunction : sec_bot_exp
   task automatic check(input string nm, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic complete_run;
      $display("mismatches %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic do_op(input fsd_pkg::fsd_op_e op, input fsd_pkg::fsd_id_e id,
                        input logic [16:0] x, input bit wt);
      int n;
      valid = 1'b1;
      req = '{op, id, x, x[7:0] ^ x[15:8]};
      for (n = 0; ready !== 1'b1 && n < 400; n++) @(negedge clk);
      @(negedge clk);
      valid = 1'b0;
      for (n = 0; wt && done !== 1'b1 && n < 400; n++) @(negedge clk);
      if (n == 400) begin
         error_cnt++;
         complete_run();
      end
   endtask : do_op
   task automatic rd_chk(input logic [16:0] x, input logic [7:0] e);
      do_op(fsd_pkg::OP_READ, fsd_pkg::ID_MAKER, x, 1'b1);
      check("read data", e, rdata);
      check("sector", {4'h0, sec_exp(x)}, {4'h0, sector});
      check("boot sector", {4'h0, sec_bot_exp(x)}, {4'h0, sector_b});
   endtask : rd_chk
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      valid = 1'b0;
      req = '0;
      flt = 8'h5a;
      lfsr = 32'hc81a;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 16; i++) begin
         lfsr = lfsr_next(lfsr);
         a = (i < 8) ? corner[i] : lfsr[16:0];
         rd_chk(a, mem_exp(a));
      end
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         a = {(i < 3) ? 3'h2 : lfsr[16:14] | 3'h4, lfsr[13:0]};
         do_op(fsd_pkg::OP_ID_HV, fsd_pkg::fsd_id_e'(2'(i % 3)), a, 1'b1);
         check("id", (i % 3 == 0) ? MAKER_ID : (i % 3 == 1) ? DEV_ID
            : {7'h00, i < 3}, rdata);
         if (i % 3 == 2)
            check("prot", {7'h00, i < 3}, {7'h00, prot});
      end
      do_op(fsd_pkg::OP_ID_CMD, fsd_pkg::ID_DEVICE, 17'h00000, 1'b1);
      check("cmd id", DEV_ID, rdata);
      rd_chk(17'h00000, MAKER_ID);
      do_op(fsd_pkg::OP_EXIT_ID, fsd_pkg::ID_MAKER, 17'h00000, 1'b1);
      rd_chk(17'h00001, mem_exp(17'h00001));
      do_op(fsd_pkg::OP_WRITE, fsd_pkg::ID_MAKER, 17'h0abcd, 1'b1);
      rd_chk(17'h0abcd, mem_exp(17'h0abcd));
      do_op(fsd_pkg::OP_ID_CMD, fsd_pkg::ID_MAKER, 17'h00000, 1'b1);
      do_op(fsd_pkg::OP_CLEAR, fsd_pkg::ID_MAKER, 17'h00000, 1'b1);
      rd_chk(17'h00100, mem_exp(17'h00100));
      do_op(fsd_pkg::OP_STANDBY, fsd_pkg::ID_MAKER, 17'h00000, 1'b0);
      repeat (4) @(negedge clk);
      for (int i = 0; i < 30; i++) begin
         check("standby", 8'h00, {7'h00, clear_n | moe});
         @(negedge clk);
      end
      do_op(fsd_pkg::OP_READ, fsd_pkg::ID_MAKER, 17'h00000, 1'b1);
      rd_chk(17'h1c123, mem_exp(17'h1c123));
      complete_run();
   end
endmodule : tb
`default_nettype wire
